// ---- rtl/tmcfg_pkg.sv ----
/*
 * Constants shared by the temperature monitor configuration registers:
 * pointer addresses, reset values, field positions and the ideality base.
 * Assumes nothing of its surroundings; imported by every design file.
 */
package tmcfg_pkg;

    // Pointer addresses
    localparam logic [7:0] TMCFG_PTR_HYST      = 8'h21;
    localparam logic [7:0] TMCFG_PTR_FAULT     = 8'h22;
    localparam logic [7:0] TMCFG_PTR_IDEAL     = 8'h23;
    localparam logic [7:0] TMCFG_PTR_AVG       = 8'h24;
    localparam logic [7:0] TMCFG_PTR_MAKER     = 8'hfe;

    // Values after reset
    localparam logic [7:0] TMCFG_HYST_RST      = 8'h0a;
    localparam logic [7:0] TMCFG_FAULT_RST     = 8'h01;
    localparam logic [7:0] TMCFG_IDEAL_RST     = 8'h00;
    localparam logic [1:0] TMCFG_AVG_RST       = 2'h0;

    // Field positions
    localparam int         TMCFG_TIMEOUT_BIT   = 7;
    localparam int         TMCFG_CNT_MSB       = 3;
    localparam int         TMCFG_CNT_LSB       = 1;
    localparam int         TMCFG_AVG_MSB       = 1;

    // Consecutive fault codes and counts
    localparam logic [2:0] TMCFG_CNT_CODE1     = 3'h0;
    localparam logic [2:0] TMCFG_CNT_CODE2     = 3'h1;
    localparam logic [2:0] TMCFG_CNT_CODE3     = 3'h3;
    localparam logic [2:0] TMCFG_CNT_CODE4     = 3'h7;

    // Averaging codes and sample counts
    localparam logic [1:0] TMCFG_AVG_CODE_OFF  = 2'h0;
    localparam logic [1:0] TMCFG_AVG_CODE_4    = 2'h1;
    localparam logic [1:0] TMCFG_AVG_CODE_8    = 2'h2;
    localparam logic [3:0] TMCFG_AVG_NUM_OFF   = 4'h0;
    localparam logic [3:0] TMCFG_AVG_NUM_4     = 4'h4;
    localparam logic [3:0] TMCFG_AVG_NUM_8     = 4'h8;

    // Ideality base term and widths
    localparam int         TMCFG_DEN_W         = 13;
    localparam logic [12:0] TMCFG_IDEAL_BASE   = 13'h0828;
    localparam int         TMCFG_RAW_W         = 16;

endpackage

// ---- rtl/tmcfg_scale.sv ----
/*
 * Remote ideality scaler: multiplies an absolute-temperature code by
 * (base + signed adjust) / base. Local codes pass untouched.
 * Assumes a combinational path; the caller registers the result.
 */
`timescale 1ns/100ps
module tmcfg_scale
    import tmcfg_pkg::*;
#(
    parameter int RAW_W = tmcfg_pkg::TMCFG_RAW_W
) (
    input  wire logic [RAW_W-1:0] raw_i,
    input  wire logic             remote_i,
    input  wire logic [7:0]       adjust_i,
    output logic      [RAW_W-1:0] result_o
);
    import tmcfg_pkg::*;

    localparam int PW = RAW_W + TMCFG_DEN_W;

    logic [TMCFG_DEN_W-1:0] den;
    logic [PW-1:0]          prod;
    logic [PW-1:0]          quo;

    always_comb begin
        den  = TMCFG_IDEAL_BASE + {{(TMCFG_DEN_W-8){adjust_i[7]}}, adjust_i};
        prod = {{TMCFG_DEN_W{1'b0}}, raw_i} * {{RAW_W{1'b0}}, den};
        quo  = prod / {{RAW_W{1'b0}}, TMCFG_IDEAL_BASE};
        if (!remote_i) begin
            result_o = raw_i;
        end else if (|quo[PW-1:RAW_W]) begin
            result_o = {RAW_W{1'b1}};
        end else begin
            result_o = quo[RAW_W-1:0];
        end
    end

endmodule

// ---- rtl/tmcfg_regs.sv ----
/*
 * Configuration and identification registers of the temperature monitor:
 * hysteresis, fault count with time-out enable, ideality correction,
 * averaging select, maker code; overtemperature and alert gating.
 * Assumes the bus engine decodes the pointer and gives one-cycle strobes.
 */
`timescale 1ns/100ps
// Contract
// - Hysteresis applied, one degree per step
// - Bit 7 enables bus time-out, reset off
// - Codes 0,1,3,7 need 1..4 faults
// - Ideality adjust is signed eight bits
// - Factor is 1.008*2088/(2088+adjust); code scales by (2088+adjust)/2088
// - Adjust resets zero, nominal factor
// - Adjust affects remote results only
// - Ideality adjust written/read at 23h
// - Averaging select bits 1:0, reset off
// - Read-only maker code at FEh
// - Hysteresis at 21h, reset 0Ah
// - Remote compared to overtemperature limit
module tmcfg_regs
    import tmcfg_pkg::*;
#(
    parameter logic [7:0] MAKER_CODE = 8'ha5,
    parameter int         RAW_W      = tmcfg_pkg::TMCFG_RAW_W
) (
    input  wire logic             sys_clk_i,
    input  wire logic             rst_i,
    input  wire logic [7:0]       reg_ptr_i,
    input  wire logic             reg_wr_i,
    input  wire logic             reg_rd_i,
    input  wire logic [7:0]       reg_wdata_i,
    output logic      [7:0]       reg_rdata_o,
    output logic                  reg_rvalid_o,
    input  wire logic             meas_done_i,
    input  wire logic             meas_remote_i,
    input  wire logic             out_of_limit_i,
    input  wire logic [RAW_W-1:0] meas_raw_i,
    input  wire logic [7:0]       remote_temp_i,
    input  wire logic [7:0]       overtemp_limit_i,
    output logic                  overtemp_output_o,
    output logic                  alert_o,
    output logic                  bus_timeout_enable_o,
    output logic      [7:0]       hysteresis_value_o,
    output logic      [7:0]       ideality_adjust_bits_o,
    output logic      [1:0]       averaging_select_o,
    output logic      [3:0]       averaging_count_o,
    output logic      [RAW_W-1:0] conv_result_o,
    output logic                  conv_valid_o,
    output logic                  conv_remote_o
);
    import tmcfg_pkg::*;

    // MAKER_CODE default is an arbitrary neutral value

    typedef struct packed {
        logic [7:0]       hyst;
        logic [7:0]       fault_cfg;
        logic [7:0]       ideal;
        logic [1:0]       avg;
        logic [3:0]       avg_num;
        logic [7:0]       rdata;
        logic             rvalid;
        logic [2:0]       fault_cnt;
        logic             alert;
        logic             overtemp;
        logic [RAW_W-1:0] conv;
        logic             conv_valid;
        logic             conv_remote;
    } tmcfg_state_t;

    tmcfg_state_t     st_reg;
    tmcfg_state_t     st_next;
    logic [RAW_W-1:0] scaled;
    logic [2:0]       need;
    logic [7:0]       clear_lvl;

    // Required consecutive faults for a count code
    function automatic logic [2:0] fault_need(input logic [2:0] code);
        case (code)
            TMCFG_CNT_CODE1: fault_need = 3'h1;
            TMCFG_CNT_CODE2: fault_need = 3'h2;
            TMCFG_CNT_CODE3: fault_need = 3'h3;
            TMCFG_CNT_CODE4: fault_need = 3'h4;
            default:         fault_need = 3'h1;
        endcase
    endfunction

    // Averaged sample count for a select code
    function automatic logic [3:0] avg_num(input logic [1:0] code);
        case (code)
            TMCFG_AVG_CODE_4: avg_num = TMCFG_AVG_NUM_4;
            TMCFG_AVG_CODE_8: avg_num = TMCFG_AVG_NUM_8;
            default:          avg_num = TMCFG_AVG_NUM_OFF;
        endcase
    endfunction

    tmcfg_scale #(
        .RAW_W    (RAW_W)
    ) u_scale (
        .raw_i    (meas_raw_i),
        .remote_i (meas_remote_i),
        .adjust_i (st_reg.ideal),
        .result_o (scaled)
    );

    always_comb begin
        st_next   = st_reg;
        need      = fault_need(st_reg.fault_cfg[TMCFG_CNT_MSB:TMCFG_CNT_LSB]);
        clear_lvl = (overtemp_limit_i > st_reg.hyst) ? overtemp_limit_i - st_reg.hyst : 8'h00;

        // Register writes
        if (reg_wr_i) begin
            case (reg_ptr_i)
                TMCFG_PTR_HYST:  st_next.hyst = reg_wdata_i;
                TMCFG_PTR_FAULT: st_next.fault_cfg = reg_wdata_i;
                TMCFG_PTR_IDEAL: st_next.ideal = reg_wdata_i;
                TMCFG_PTR_AVG: begin
                    st_next.avg     = reg_wdata_i[TMCFG_AVG_MSB:0];
                    st_next.avg_num = avg_num(reg_wdata_i[TMCFG_AVG_MSB:0]);
                end
                default: ;
            endcase
        end

        // Register reads, one cycle latency
        st_next.rvalid = reg_rd_i;
        if (reg_rd_i) begin
            case (reg_ptr_i)
                TMCFG_PTR_HYST:  st_next.rdata = st_reg.hyst;
                TMCFG_PTR_FAULT: st_next.rdata = st_reg.fault_cfg;
                TMCFG_PTR_IDEAL: st_next.rdata = st_reg.ideal;
                TMCFG_PTR_AVG:   st_next.rdata = {6'h00, st_reg.avg};
                TMCFG_PTR_MAKER: st_next.rdata = MAKER_CODE;
                default:         st_next.rdata = 8'h00;
            endcase
        end

        if (meas_done_i) begin
            if (out_of_limit_i) begin
                if (st_reg.fault_cnt + 3'h1 >= need) begin
                    st_next.alert     = 1'b1;
                    st_next.fault_cnt = need;
                end else begin
                    st_next.fault_cnt = st_reg.fault_cnt + 3'h1;
                end
            end else begin
                st_next.alert     = 1'b0;
                st_next.fault_cnt = 3'h0;
            end
        end

        if (meas_done_i && meas_remote_i) begin
            if (remote_temp_i >= overtemp_limit_i) begin
                st_next.overtemp = 1'b1;
            end else if (remote_temp_i <= clear_lvl) begin
                st_next.overtemp = 1'b0;
            end
        end

        st_next.conv_valid = meas_done_i;
        if (meas_done_i) begin
            st_next.conv        = scaled;
            st_next.conv_remote = meas_remote_i;
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            st_reg             <= '0;
            st_reg.hyst        <= TMCFG_HYST_RST;
            st_reg.fault_cfg   <= TMCFG_FAULT_RST;
            st_reg.ideal       <= TMCFG_IDEAL_RST;
            st_reg.avg         <= TMCFG_AVG_RST;
            st_reg.avg_num     <= TMCFG_AVG_NUM_OFF;
        end else begin
            st_reg <= st_next;
        end
    end

    assign reg_rdata_o            = st_reg.rdata;
    assign reg_rvalid_o           = st_reg.rvalid;
    assign overtemp_output_o      = st_reg.overtemp;
    assign alert_o                = st_reg.alert;
    assign bus_timeout_enable_o   = st_reg.fault_cfg[TMCFG_TIMEOUT_BIT];
    assign hysteresis_value_o     = st_reg.hyst;
    assign ideality_adjust_bits_o = st_reg.ideal;
    assign averaging_select_o     = st_reg.avg;
    assign averaging_count_o      = st_reg.avg_num;
    assign conv_result_o          = st_reg.conv;
    assign conv_valid_o           = st_reg.conv_valid;
    assign conv_remote_o          = st_reg.conv_remote;

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);

    property p_hyst_wr;
        reg_wr_i && reg_ptr_i == TMCFG_PTR_HYST ##1 !reg_wr_i ##1 reg_rd_i
            && reg_ptr_i == TMCFG_PTR_HYST && !reg_wr_i |=> reg_rdata_o == $past(reg_wdata_i, 3);
    endproperty
    a_hyst_wr: assert property (p_hyst_wr) else $error("hysteresis readback wrong");

    property p_timeout;
        reg_wr_i && reg_ptr_i == TMCFG_PTR_FAULT |=> bus_timeout_enable_o == $past(reg_wdata_i[7]);
    endproperty
    a_timeout: assert property (p_timeout) else $error("time-out enable wrong");

    property p_four_faults;
        st_reg.fault_cfg[3:1] == 3'h7 && !alert_o && st_reg.fault_cnt == 3'h0
            && meas_done_i && out_of_limit_i |=> !alert_o;
    endproperty
    a_four_faults: assert property (p_four_faults) else $error("alert too early");

    property p_bad_code;
        st_reg.fault_cfg[3:1] == 3'h5 && meas_done_i && out_of_limit_i |=> alert_o;
    endproperty
    a_bad_code: assert property (p_bad_code) else $error("undefined code blocked alert");

    property p_ideal_rd;
        reg_rd_i && reg_ptr_i == TMCFG_PTR_IDEAL |=>
            reg_rvalid_o && reg_rdata_o == $past(ideality_adjust_bits_o);
    endproperty
    a_ideal_rd: assert property (p_ideal_rd) else $error("ideality readback wrong");

    property p_scale_neg;
        meas_done_i && meas_remote_i && st_reg.ideal == 8'hf6 && meas_raw_i == 16'h0828
            |=> conv_result_o == 16'h081e;
    endproperty
    a_scale_neg: assert property (p_scale_neg) else $error("signed adjust wrong");

    property p_nominal;
        meas_done_i && st_reg.ideal == 8'h00 |=> conv_valid_o && conv_result_o == $past(meas_raw_i);
    endproperty
    a_nominal: assert property (p_nominal) else $error("zero adjust changed result");

    property p_local;
        meas_done_i && !meas_remote_i |=> !conv_remote_o && conv_result_o == $past(meas_raw_i);
    endproperty
    a_local: assert property (p_local) else $error("local result was scaled");

    property p_avg_rd;
        reg_rd_i && reg_ptr_i == TMCFG_PTR_AVG |=> reg_rdata_o[7:2] == 6'h00;
    endproperty
    a_avg_rd: assert property (p_avg_rd) else $error("averaging reserved bits set");

    property p_maker;
        reg_rd_i && reg_ptr_i == TMCFG_PTR_MAKER |=> reg_rdata_o == MAKER_CODE;
    endproperty
    a_maker: assert property (p_maker) else $error("maker code wrong");

    property p_ot_set;
        meas_done_i && meas_remote_i && remote_temp_i >= overtemp_limit_i |=> overtemp_output_o;
    endproperty
    a_ot_set: assert property (p_ot_set) else $error("overtemperature not set");

    property p_ot_hold;
        overtemp_output_o && meas_done_i && meas_remote_i && remote_temp_i > clear_lvl
            |=> overtemp_output_o;
    endproperty
    a_ot_hold: assert property (p_ot_hold) else $error("released inside hysteresis");

    c_alert: cover property ($rose(alert_o));
    c_ot_clear: cover property ($fell(overtemp_output_o));
    c_maker_rd: cover property (reg_rd_i && reg_ptr_i == TMCFG_PTR_MAKER);

endmodule

// ---- tb/tmcfg_host.sv ----
/*
 * Host model on the register port: single-byte writes and reads.
 * Assumes one-cycle strobes and an rvalid pulse one cycle after a read.
 */
`timescale 1ns/100ps
module tmcfg_host (
    input  wire logic       sys_clk_i,
    output logic      [7:0] ptr_o,
    output logic            wr_o,
    output logic            rd_o,
    output logic      [7:0] wdata_o,
    input  wire logic [7:0] rdata_i,
    input  wire logic       rvalid_i
);
    initial begin
        ptr_o   = 8'h00;
        wr_o    = 1'b0;
        rd_o    = 1'b0;
        wdata_o = 8'h00;
    end
    task automatic wr_byte(input logic [7:0] p, input logic [7:0] d);
        @(posedge sys_clk_i);
        ptr_o   <= p;
        wdata_o <= d;
        wr_o    <= 1'b1;
        @(posedge sys_clk_i);
        wr_o    <= 1'b0;
        ptr_o   <= ~p;
        wdata_o <= ~d;
    endtask
    task automatic rd_byte(input logic [7:0] p, output logic [7:0] d, output bit ok);
        ok = 1'b0;
        d  = 8'h00;
        @(posedge sys_clk_i);
        ptr_o <= p;
        rd_o  <= 1'b1;
        @(posedge sys_clk_i);
        rd_o  <= 1'b0;
        ptr_o <= ~p;
        for (int i = 0; i < 4 && !ok; i++) begin
            #1;
            if (rvalid_i === 1'b1) begin
                d  = rdata_i;
                ok = 1'b1;
            end else begin
                @(posedge sys_clk_i);
            end
        end
    endtask
endmodule

// ---- tb/tmcfg_tb.sv ----
/*
 * Top bench: register checks and measurements against an integer model.
 * Assumes the host model and the register block of the design.
 */
`timescale 1ns/100ps
module tb_top;
    import tmcfg_pkg::*;
    localparam logic [7:0] MAKER = 8'h3c; // Arbitrary maker code
    logic        sys_clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic [7:0]  ptr, wdata, rdata, hyst, adj, temp = 8'h00, lim = 8'h64;
    logic        wr, rd, rvalid, ot, alert, tmo, cvalid, crem;
    logic        mdone = 1'b0, mrem = 1'b0, oof = 1'b0;
    logic [15:0] raw = 16'h0000, res;
    logic [1:0]  asel;
    logic [3:0]  acnt;
    int          failures = 0, tests_run = 0, seed = 32'h507373be;
    int          need = 1, fcnt = 0, hm = 10, am = 0, lm = 100;
    bit          al_m = 1'b0, ot_m = 1'b0;
    logic [2:0]  codes [8] = '{3'h0, 3'h1, 3'h3, 3'h7, 3'h2, 3'h4, 3'h5, 3'h6};
    int          needs [8] = '{1, 2, 3, 4, 1, 1, 1, 1};
    logic [7:0]  adjs [8] = '{8'h00, 8'h7f, 8'h80, 8'hf6, 8'h01, 8'hff, 8'h0a, 8'hf8};
    logic [7:0]  rptr [6] = '{8'h21, 8'h22, 8'h23, 8'h24, 8'hfe, 8'h30};
    logic [7:0]  rexp [6] = '{8'h0a, 8'h01, 8'h00, 8'h00, MAKER, 8'h00};
    logic [3:0]  acnt_exp [4] = '{4'h0, 4'h4, 4'h8, 4'h0};
    always #5 sys_clk_i = ~sys_clk_i;
    tmcfg_host i_host (.sys_clk_i(sys_clk_i), .ptr_o(ptr), .wr_o(wr), .rd_o(rd),
        .wdata_o(wdata), .rdata_i(rdata), .rvalid_i(rvalid));
    tmcfg_regs #(.MAKER_CODE(MAKER), .RAW_W(16)) i_dut (
        .sys_clk_i(sys_clk_i), .rst_i(rst_i), .reg_ptr_i(ptr), .reg_wr_i(wr),
        .reg_rd_i(rd), .reg_wdata_i(wdata), .reg_rdata_o(rdata), .reg_rvalid_o(rvalid),
        .meas_done_i(mdone), .meas_remote_i(mrem), .out_of_limit_i(oof),
        .meas_raw_i(raw), .remote_temp_i(temp), .overtemp_limit_i(lim),
        .overtemp_output_o(ot), .alert_o(alert), .bus_timeout_enable_o(tmo),
        .hysteresis_value_o(hyst), .ideality_adjust_bits_o(adj),
        .averaging_select_o(asel), .averaging_count_o(acnt), .conv_result_o(res),
        .conv_valid_o(cvalid), .conv_remote_o(crem));
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        tests_run++;
        if (g !== e) begin
            failures++;
            $display("unexpected %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic rd_chk(input logic [7:0] p, input logic [7:0] e);
        logic [7:0] d;
        bit         ok;
        i_host.rd_byte(p, d, ok);
        if (!ok) begin
            failures++;
            conclude();
        end else begin
            chk("rdata", {8'h00, e}, {8'h00, d});
        end
    endtask
    task automatic meas(input bit r, input bit f, input logic [15:0] w, input logic [7:0] t);
        longint x;
        @(posedge sys_clk_i);
        mdone <= 1'b1;
        mrem  <= r;
        oof   <= f;
        raw   <= w;
        temp  <= t;
        @(posedge sys_clk_i);
        mdone <= 1'b0;
        raw   <= ~w;
        temp  <= ~t;
        fcnt = f ? fcnt + 1 : 0;
        al_m = f && fcnt >= need;
        x = r ? longint'(w) * (2088 + am) / 2088 : longint'(w);
        if (x > 65535) x = 65535;
        if (r && int'(t) >= lm) ot_m = 1'b1;
        else if (r && int'(t) <= ((lm > hm) ? lm - hm : 0)) ot_m = 1'b0;
        #1;
        chk("conv_valid", 16'h0001, {15'h0, cvalid});
        chk("conv_result", x[15:0], res);
        chk("conv_remote", {15'h0, r}, {15'h0, crem});
        chk("alert", {15'h0, al_m}, {15'h0, alert});
        chk("overtemp", {15'h0, ot_m}, {15'h0, ot});
    endtask
    initial begin
        logic [7:0] v;
        repeat (16) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        chk("timeout_en", 16'h0000, {15'h0, tmo});
        for (int k = 0; k < 6; k++) begin
            rd_chk(rptr[k], rexp[k]);
        end
        meas(1'b1, 1'b0, 16'h1234, 8'h10);
        for (int k = 0; k < 8; k++) begin
            v = $random(seed);
            i_host.wr_byte(TMCFG_PTR_IDEAL, adjs[k]);
            rd_chk(TMCFG_PTR_IDEAL, adjs[k]);
            chk("adjust_o", {8'h0, adjs[k]}, {8'h0, adj});
            v = {v[7:2], 2'(k)};
            i_host.wr_byte(TMCFG_PTR_AVG, v);
            rd_chk(TMCFG_PTR_AVG, {6'h0, v[1:0]});
            chk("avg_sel", {14'h0, v[1:0]}, {14'h0, asel});
            chk("avg_cnt", {12'h0, acnt_exp[v[1:0]]}, {12'h0, acnt});
            v = {v[7:4], codes[k], v[0]};
            i_host.wr_byte(TMCFG_PTR_FAULT, v);
            rd_chk(TMCFG_PTR_FAULT, v);
            chk("timeout_en", {15'h0, v[7]}, {15'h0, tmo});
            i_host.wr_byte(TMCFG_PTR_MAKER, v);
            rd_chk(TMCFG_PTR_MAKER, MAKER);
            v = $random(seed);
            v = k[0] ? v : {4'h0, v[3:0]};
            i_host.wr_byte(TMCFG_PTR_HYST, v);
            rd_chk(TMCFG_PTR_HYST, v);
            chk("hyst_o", {8'h0, v}, {8'h0, hyst});
            hm = int'(v);
            am = int'($signed(adjs[k]));
            need = needs[k];
            lm = 40 + ($random(seed) & 63);
            @(posedge sys_clk_i);
            lim <= lm[7:0];
            meas(1'b0, 1'b0, 16'(k), 8'h00);
            for (int j = 0; j < need + 2; j++) begin
                v = lm[7:0] - 8'd16 + 8'($random(seed) & 31);
                meas(1'($random(seed)), 1'b1, 16'($random(seed)), v);
            end
            meas(1'b1, 1'b0, 16'hffff, 8'h00);
            meas(1'b1, 1'b0, 16'h0828, 8'h00);
        end
        @(posedge sys_clk_i);
        rst_i <= 1'b1;
        @(posedge sys_clk_i);
        rst_i <= 1'b0;
        #1;
        chk("hyst_rst", 16'h000a, {8'h0, hyst});
        chk("adjust_rst", 16'h0000, {8'h0, adj});
        chk("alert_rst", 16'h0000, {15'h0, alert});
        conclude();
    end
endmodule
